// *** speed_select_map.vh ***
`ifndef SPEED_SELECT_MAP_VH
`define SPEED_SELECT_MAP_VH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define OFS_CONTROL        12'h000
`define OFS_INCH_FREQ      12'h004
`define OFS_INCH_RAMP      12'h008
`define OFS_TERM_FUNC      12'h00c
`define OFS_STATUS         12'h010
`define OFS_RAMP_REF       12'h014
`define OFS_PRESET_BASE    12'h040
`define OFS_PRESET_LAST    12'h078

// ****************************************************************
// Control register fields.
// ****************************************************************
`define CTL_MODE_LSB       0
`define CTL_MODE_MSB       2
`define CTL_REMOTE_LSB     4
`define CTL_REMOTE_MSB     5

// ****************************************************************
// Operation mode and remote selection values.
// ****************************************************************
`define MODE_SWITCHABLE    3'h0
`define MODE_PANEL         3'h1
`define MODE_EXTERNAL      3'h2
`define MODE_COMBINED_A    3'h3
`define MODE_COMBINED_B    3'h4
`define REMOTE_PRESET      2'h0
`define REMOTE_STORE       2'h1
`define REMOTE_NO_STORE    2'h2
`define REMOTE_CLEAR_STOP  2'h3

// ****************************************************************
// Terminal function codes.
// ****************************************************************
`define FUNC_LOW           4'h0
`define FUNC_MIDDLE        4'h1
`define FUNC_HIGH          4'h2
`define FUNC_JOG           4'h5
`define FUNC_EXTRA         4'h8

// ****************************************************************
// Frequency units of 0.1 Hz, times of 0.1 s, and reset values.
// ****************************************************************
`define PRESET_UNUSED      16'h270f
`define FREQ_MAX           16'h0fa0
`define RAMP_MAX           16'h8ca0
`define RST_HIGH           16'h0258
`define RST_MIDDLE         16'h012c
`define RST_LOW            16'h0064
`define RST_INCH_FREQ      16'h0032
`define RST_INCH_RAMP      16'h0005
`define RST_RAMP_REF       16'h0258
`define RST_TERM_FUNC      20'h85210
`define RST_CONTROL        32'h00000000

// ****************************************************************
// Command source codes shown in status.
// ****************************************************************
`define SRC_NONE           3'h0
`define SRC_JOG            3'h1
`define SRC_PRESET         3'h2
`define SRC_CURRENT        3'h3
`define SRC_VOLTAGE        3'h4

`endif

// *** function_match.v ***
`include "speed_select_map.vh"

// ****************************************************************
// Terminal function decoder.
// ****************************************************************
module function_match #(
  parameter [3:0] CODE = 4'h0
) (
  input  wire [19:0] term_func,
  input  wire [4:0]  term_in,
  output wire        active
);

  // A function is active when any terminal carrying its code is on.
  assign active = ((term_func[3:0]   == CODE) & term_in[0]) |
                  ((term_func[7:4]   == CODE) & term_in[1]) |
                  ((term_func[11:8]  == CODE) & term_in[2]) |
                  ((term_func[15:12] == CODE) & term_in[3]) |
                  ((term_func[19:16] == CODE) & term_in[4]);

endmodule

// *** preset_speed_and_jog_select.v ***
// Added by the designer: the placing of the registers and the APB interface to the registers.
`include "speed_select_map.vh"

// What this block does
// - Several of high, middle, low active with their combination preset unused: lowest-ranked active input wins.
// - Presets four to fifteen come from combinations of four select inputs.
// - A preset holding 9999 is not selected and never becomes a frequency.
// - Extra input alone with preset eight unused runs at low speed.
// - Terminal codes: 0 low, 8 extra, 1 middle, 2 high.
// - Priority: jog, presets, current analog input, voltage analog input.
// - Presets act only in switchable, external or combined operation modes.
// - Nonzero remote selection disables preset selection.
// - With jog selected, forward and reverse start inputs start and stop jog.
// - Jog runs at the inching frequency, 0 to 400 Hz, default 5 Hz.
// - Jog uses one ramp time for both directions, default 0.5 s.
// - Panel jog runs only while the run key is held.
// - During jog the second ramp selection is ignored; other second functions stay.
// - Operation mode 3 disables jog entirely.
// - Mode 4: panel run or unit forward/reverse keys start, stop key stops.
// - Remote selection: 0 presets, 1 stored, 2 unstored, 3 cleared at stop.
// - Presets four to fifteen carry no precedence among themselves.
// - High, middle, low alone select 60, 30 and 10 Hz defaults.
// - Remote selection 1 to 3 turns high, middle, low into up, down, clear.
module preset_speed_and_jog_select (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [4:0]  terminal_in,
  input  wire        forward_start_input,
  input  wire        reverse_start_input,
  input  wire        second_function_select,
  input  wire        panel_jog_mode,
  input  wire        panel_run_key,
  input  wire        panel_stop_key,
  input  wire        unit_forward_key,
  input  wire        unit_reverse_key,
  input  wire        current_input_valid,
  input  wire [15:0] current_input_freq,
  input  wire        voltage_input_valid,
  input  wire [15:0] voltage_input_freq,
  output reg  [15:0] frequency_reference,
  output reg  [2:0]  command_source,
  output reg         run_command,
  output reg         run_reverse,
  output reg         jog_running,
  output reg  [15:0] ramp_time,
  output reg  [15:0] ramp_reference,
  output reg         second_ramp_select,
  output reg         second_function_other,
  output reg         remote_increase,
  output reg         remote_decrease,
  output reg         remote_clear,
  output reg         remote_store_enable
);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  reg  [31:0] control;
  reg  [15:0] inching_frequency;
  reg  [15:0] inching_ramp_time;
  reg  [15:0] ramp_ref_freq;
  reg  [19:0] term_func;
  reg  [15:0] preset [0:14];
  reg         combined_run;
  reg         start_seen;
  integer     i;

  wire [2:0]  operation_mode_selection  = control[`CTL_MODE_MSB:`CTL_MODE_LSB];
  wire [1:0]  remote_function_selection = control[`CTL_REMOTE_MSB:`CTL_REMOTE_LSB];

  // ****************************************************************
  // Terminal function decode.
  // ****************************************************************
  wire low_speed_select_input;
  wire middle_speed_select_input;
  wire high_speed_select_input;
  wire extra_speed_select_input;
  wire jog_select_input;

  // Each function is found by its code on any assignable terminal.
  function_match #(.CODE(`FUNC_LOW)) u_low (
    .term_func (term_func),
    .term_in   (terminal_in),
    .active    (low_speed_select_input)
  );
  function_match #(.CODE(`FUNC_MIDDLE)) u_middle (
    .term_func (term_func),
    .term_in   (terminal_in),
    .active    (middle_speed_select_input)
  );
  function_match #(.CODE(`FUNC_HIGH)) u_high (
    .term_func (term_func),
    .term_in   (terminal_in),
    .active    (high_speed_select_input)
  );
  function_match #(.CODE(`FUNC_EXTRA)) u_extra (
    .term_func (term_func),
    .term_in   (terminal_in),
    .active    (extra_speed_select_input)
  );
  function_match #(.CODE(`FUNC_JOG)) u_jog (
    .term_func (term_func),
    .term_in   (terminal_in),
    .active    (jog_select_input)
  );

  // ****************************************************************
  // Preset speed selection.
  // ****************************************************************
  wire [3:0]  combo = {extra_speed_select_input, high_speed_select_input,
                       middle_speed_select_input, low_speed_select_input};
  reg  [3:0]  table_index;
  reg         table_hit;
  reg  [15:0] table_value;
  reg  [15:0] basic_value;
  reg         basic_hit;
  reg  [15:0] preset_value;
  reg         preset_hit;

  // Fixed table from input combination to preset slot; slot 15 means none.
  always @* begin
    case (combo)
      4'h1:    table_index = 4'h2;
      4'h2:    table_index = 4'h1;
      4'h4:    table_index = 4'h0;
      4'h3:    table_index = 4'h3;
      4'h5:    table_index = 4'h4;
      4'h6:    table_index = 4'h5;
      4'h7:    table_index = 4'h6;
      4'h8:    table_index = 4'h7;
      4'h9:    table_index = 4'h8;
      4'ha:    table_index = 4'h9;
      4'hb:    table_index = 4'ha;
      4'hc:    table_index = 4'hb;
      4'hd:    table_index = 4'hc;
      4'he:    table_index = 4'hd;
      4'hf:    table_index = 4'he;
      default: table_index = 4'hf;
    endcase
  end

  // The table gives exactly one slot; unused slots fall back to the basic three.
  always @* begin
    table_value = 16'h0000;
    table_hit   = 1'b0;
    if (table_index != 4'hf) begin
      table_value = preset[table_index];
      table_hit   = (table_value != `PRESET_UNUSED);
    end
  end

  // The lowest-ranked active basic input wins; extra alone falls to low speed.
  always @* begin
    basic_hit   = 1'b1;
    basic_value = 16'h0000;
    if (low_speed_select_input)         basic_value = preset[2];
    else if (middle_speed_select_input) basic_value = preset[1];
    else if (high_speed_select_input)   basic_value = preset[0];
    else if (extra_speed_select_input)  basic_value = preset[2];
    else                                basic_hit   = 1'b0;
  end

  // Presets apply only with remote setting off and outside the panel mode; the mode field
  // is limited to 0 to 4 on write, so every other mode is an external style one.
  always @* begin
    preset_value = table_hit ? table_value : basic_value;
    preset_hit   = (table_hit | basic_hit) &
                   (operation_mode_selection != `MODE_PANEL) &
                   (remote_function_selection == `REMOTE_PRESET);
  end

  // ****************************************************************
  // Jog and start decisions.
  // ****************************************************************
  wire start_any  = forward_start_input | reverse_start_input;
  wire mode_jog_ok = (operation_mode_selection != `MODE_COMBINED_A);
  wire ext_jog    = mode_jog_ok & jog_select_input & start_any &
                    (operation_mode_selection != `MODE_PANEL);
  wire panel_jog  = mode_jog_ok & panel_jog_mode & panel_run_key &
                    (operation_mode_selection == `MODE_PANEL |
                     operation_mode_selection == `MODE_SWITCHABLE);
  wire jog_now    = ext_jog | panel_jog;
  wire panel_start = panel_run_key | unit_forward_key | unit_reverse_key;

  reg         next_combined_run;

  // In mode 4 the panel keys latch a run that the stop key ends.
  always @* begin
    next_combined_run = combined_run;
    if (operation_mode_selection != `MODE_COMBINED_B) begin
      next_combined_run = 1'b0;
    end else if (panel_stop_key) begin
      next_combined_run = 1'b0;
    end else if (panel_start) begin
      next_combined_run = 1'b1;
    end
  end

  // ****************************************************************
  // Frequency command arbitration.
  // ****************************************************************
  reg  [15:0] next_freq;
  reg  [2:0]  next_source;

  // Fixed priority order among the external frequency commands.
  always @* begin
    if (jog_now) begin
      next_freq   = inching_frequency;
      next_source = `SRC_JOG;
    end else if (preset_hit) begin
      next_freq   = preset_value;
      next_source = `SRC_PRESET;
    end else if (current_input_valid) begin
      next_freq   = current_input_freq;
      next_source = `SRC_CURRENT;
    end else if (voltage_input_valid) begin
      next_freq   = voltage_input_freq;
      next_source = `SRC_VOLTAGE;
    end else begin
      next_freq   = 16'h0000;
      next_source = `SRC_NONE;
    end
  end

  // ****************************************************************
  // Registered outputs towards the ramp generator.
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frequency_reference   <= 16'h0000;
      command_source        <= `SRC_NONE;
      run_command           <= 1'b0;
      run_reverse           <= 1'b0;
      jog_running           <= 1'b0;
      ramp_time             <= 16'h0000;
      ramp_reference        <= 16'h0000;
      second_ramp_select    <= 1'b0;
      second_function_other <= 1'b0;
      remote_increase       <= 1'b0;
      remote_decrease       <= 1'b0;
      remote_clear          <= 1'b0;
      remote_store_enable   <= 1'b0;
      combined_run          <= 1'b0;
      start_seen            <= 1'b0;
    end else begin
      frequency_reference   <= next_freq;
      command_source        <= next_source;
      combined_run          <= next_combined_run;
      start_seen            <= start_any;
      jog_running           <= jog_now;
      run_command           <= jog_now | next_combined_run |
                               (start_any & operation_mode_selection != `MODE_PANEL);
      run_reverse           <= reverse_start_input & ~forward_start_input & (operation_mode_selection != `MODE_PANEL);
      ramp_time             <= jog_now ? inching_ramp_time : 16'h0000;
      ramp_reference        <= ramp_ref_freq;
      second_ramp_select    <= second_function_select & ~jog_now;
      second_function_other <= second_function_select;
      // Remote setting reuses the basic inputs as up, down and clear.
      if (remote_function_selection != `REMOTE_PRESET && !jog_now) begin
        remote_increase     <= high_speed_select_input;
        remote_decrease     <= middle_speed_select_input;
        remote_clear        <= low_speed_select_input |
                               (remote_function_selection == `REMOTE_CLEAR_STOP &
                                start_seen & ~start_any);
      end else begin
        remote_increase     <= 1'b0;
        remote_decrease     <= 1'b0;
        remote_clear        <= 1'b0;
      end
      remote_store_enable   <= (remote_function_selection == `REMOTE_STORE);
    end
  end

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  wire        setup_phase = psel & ~penable;
  wire        write_now   = psel & penable & pready & pwrite;
  wire        in_presets  = (paddr >= `OFS_PRESET_BASE) & (paddr <= `OFS_PRESET_LAST) &
                            (paddr[1:0] == 2'h0);
  wire [11:0] preset_ofs  = paddr - `OFS_PRESET_BASE;
  reg  [31:0] read_word;
  reg         mapped;

  // Read mux and address decode; unmapped addresses answer with an error.
  always @* begin
    mapped    = 1'b1;
    read_word = 32'h00000000;
    if (in_presets) begin
      read_word = {16'h0000, preset[preset_ofs[5:2]]};
    end else begin
      case (paddr)
        `OFS_CONTROL:   read_word = control;
        `OFS_INCH_FREQ: read_word = {16'h0000, inching_frequency};
        `OFS_INCH_RAMP: read_word = {16'h0000, inching_ramp_time};
        `OFS_TERM_FUNC: read_word = {12'h000, term_func};
        `OFS_STATUS:    read_word = {8'h00, run_reverse, run_command, jog_running,
                                     2'h0, command_source, frequency_reference};
        `OFS_RAMP_REF:  read_word = {16'h0000, ramp_ref_freq};
        default:        mapped    = 1'b0;
      endcase
    end
  end

  // Answer is prepared in the setup cycle so the access phase ends at once.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~mapped;
      prdata  <= (setup_phase & ~pwrite & mapped) ? read_word : 32'h00000000;
    end
  end

  // Register writes; frequencies and times beyond range are limited.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control           <= `RST_CONTROL;
      inching_frequency <= `RST_INCH_FREQ;
      inching_ramp_time <= `RST_INCH_RAMP;
      ramp_ref_freq     <= `RST_RAMP_REF;
      term_func         <= `RST_TERM_FUNC;
      preset[0]         <= `RST_HIGH;
      preset[1]         <= `RST_MIDDLE;
      preset[2]         <= `RST_LOW;
      for (i = 3; i < 15; i = i + 1) begin
        preset[i]       <= `PRESET_UNUSED;
      end
    end else if (write_now && mapped) begin
      if (in_presets) begin
        if (pwdata[15:0] == `PRESET_UNUSED && preset_ofs[5:2] > 4'h2) begin
          preset[preset_ofs[5:2]] <= `PRESET_UNUSED;
        end else if (pwdata[15:0] > `FREQ_MAX) begin
          preset[preset_ofs[5:2]] <= `FREQ_MAX;
        end else begin
          preset[preset_ofs[5:2]] <= pwdata[15:0];
        end
      end else begin
        case (paddr)
          `OFS_CONTROL:   control <= {26'h0, pwdata[`CTL_REMOTE_MSB:`CTL_REMOTE_LSB], 1'b0,
                                     (pwdata[2:0] > `MODE_COMBINED_B) ? `MODE_COMBINED_B : pwdata[2:0]};
          `OFS_INCH_FREQ: inching_frequency <= (pwdata[15:0] > `FREQ_MAX) ? `FREQ_MAX : pwdata[15:0];
          `OFS_INCH_RAMP: inching_ramp_time <= (pwdata[15:0] > `RAMP_MAX) ? `RAMP_MAX : pwdata[15:0];
          `OFS_TERM_FUNC: term_func <= pwdata[19:0];
          `OFS_RAMP_REF:  ramp_ref_freq <= (pwdata[15:0] > `FREQ_MAX) ? `FREQ_MAX : pwdata[15:0];
          default:        term_func <= term_func;
        endcase
      end
    end
  end

endmodule

// *** pjs_checker.sv ***
`include "speed_select_map.vh"

// ****************************************************************
// Port checks for the preset speed and jog selector.
// ****************************************************************
module pjs_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        second_function_select,
  input wire logic        current_input_valid,
  input wire logic [2:0]  command_source,
  input wire logic        run_command,
  input wire logic        run_reverse,
  input wire logic        jog_running,
  input wire logic [15:0] ramp_time,
  input wire logic        second_ramp_select,
  input wire logic        second_function_other,
  input wire logic        remote_increase,
  input wire logic        remote_decrease,
  input wire logic        remote_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A setup cycle is answered in the next cycle, for one cycle only.
  a_access_follows: assert property (psel && !penable |=> pready)
    else $error("setup cycle not answered");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Jog outranks every other command and has its own ramp.
  a_jog_source: assert property (jog_running |-> command_source == `SRC_JOG)
    else $error("jog not reported as source");
  a_jog_ramp_only: assert property (!jog_running |-> ramp_time == 16'h0000)
    else $error("ramp time outside jog");
  a_second_ramp: assert property (second_ramp_select |-> !jog_running && second_function_other)
    else $error("second ramp during jog");
  a_second_other: assert property ($past(presetn) |-> second_function_other == $past(second_function_select))
    else $error("second function not passed on");
  a_remote_quiet: assert property (jog_running |-> !(remote_increase || remote_decrease || remote_clear))
    else $error("remote control during jog");
  a_analog_order: assert property (command_source == `SRC_VOLTAGE |-> !$past(current_input_valid))
    else $error("voltage input beat current input");
  a_reverse_run: assert property (run_reverse |-> run_command)
    else $error("reverse without run");
  c_jog: cover property (jog_running);
  c_preset: cover property (command_source == `SRC_PRESET);
  c_error: cover property (pslverr);
endmodule

bind preset_speed_and_jog_select pjs_checker chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .second_function_select, .current_input_valid, .command_source, .run_command, .run_reverse,
  .jog_running, .ramp_time, .second_ramp_select, .second_function_other, .remote_increase,
  .remote_decrease, .remote_clear);

// *** contact_model.sv ***
// ****************************************************************
// Contact switches wired to the terminals in their default roles.
// ****************************************************************
module contact_model (
  input  wire logic       pclk,
  input  wire logic [3:0] combo,
  input  wire logic       jog,
  output logic      [4:0] terminal_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contacts move just after an edge: t0 low, t1 middle, t2 high, t3 jog, t4 extra.
  always @(posedge pclk) begin
    terminal_in <= {combo[3], jog, combo[2], combo[1], combo[0]};
  end
endmodule

// *** preset_speed_and_jog_select_tb.sv ***
`include "speed_select_map.vh"

module preset_speed_and_jog_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  tin;
  logic [3:0]  combo;
  logic        jog, fwd, rev, sfs, pjm, prk, psk, ufk, urk, civ, viv;
  logic [15:0] cif, vif, freq, rtime, rref;
  logic [2:0]  src;
  logic        run, rrev, jogr, srs, sfo, rinc, rdec, rclr, rste;
  int          failures, total_checks, cycles;

  contact_model sw (.pclk(pclk), .combo(combo), .jog(jog), .terminal_in(tin));
  preset_speed_and_jog_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .terminal_in(tin), .forward_start_input(fwd), .reverse_start_input(rev), .second_function_select(sfs),
    .panel_jog_mode(pjm), .panel_run_key(prk), .panel_stop_key(psk), .unit_forward_key(ufk),
    .unit_reverse_key(urk), .current_input_valid(civ), .current_input_freq(cif), .voltage_input_valid(viv),
    .voltage_input_freq(vif), .frequency_reference(freq), .command_source(src), .run_command(run),
    .run_reverse(rrev), .jog_running(jogr), .ramp_time(rtime), .ramp_reference(rref), .second_ramp_select(srs),
    .second_function_other(sfo), .remote_increase(rinc), .remote_decrease(rdec), .remote_clear(rclr),
    .remote_store_enable(rste));

  // Free-running 50 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic final_report;
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer, holding the request until ready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Sets the contacts and lets the model and the registered outputs follow.
  task automatic drv(input logic [3:0] c, input logic j, input logic f, input logic r);
    combo <= c;
    jog   <= j;
    fwd   <= f;
    rev   <= r;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_defaults;
    apb(1'b0, `OFS_CONTROL, 32'h0);
    chk("control", 32'h0, rd);
    apb(1'b0, `OFS_INCH_FREQ, 32'h0);
    chk("inching freq", 32'h32, rd);
    apb(1'b0, `OFS_INCH_RAMP, 32'h0);
    chk("inching ramp", 32'h5, rd);
    apb(1'b0, `OFS_TERM_FUNC, 32'h0);
    chk("terminal codes", 32'h85210, rd);
    for (int k = 0; k < 15; k++) begin
      apb(1'b0, 12'(`OFS_PRESET_BASE + 4 * k), 32'h0);
      chk("preset", k == 0 ? 32'h258 : k == 1 ? 32'h12c : k == 2 ? 32'h64 : 32'h270f, rd);
    end
    apb(1'b1, 12'h100, 32'h1);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b1, `OFS_PRESET_BASE, 32'h270f);
    apb(1'b0, `OFS_PRESET_BASE, 32'h0);
    chk("high clamp", 32'hfa0, rd);
    apb(1'b1, `OFS_PRESET_BASE, 32'h258);
  endtask

  task automatic t_three;
    logic [3:0]  c3 [7] = '{4'h4, 4'h2, 4'h1, 4'h6, 4'h7, 4'h3, 4'h5};
    logic [15:0] f3 [7] = '{16'h258, 16'h12c, 16'h64, 16'h12c, 16'h64, 16'h64, 16'h64};
    apb(1'b1, `OFS_CONTROL, 32'h2);
    for (int i = 0; i < 7; i++) begin
      drv(c3[i], 1'b0, 1'b0, 1'b0);
      chk("three speed", 32'(f3[i]), 32'(freq));
      chk("preset source", 32'(`SRC_PRESET), 32'(src));
    end
  endtask

  task automatic t_multi;
    logic [3:0] cm [12] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    for (int s = 4; s < 16; s++) apb(1'b1, 12'(`OFS_PRESET_BASE + 4 * (s - 1)), 32'h100 + s);
    for (int s = 4; s < 16; s++) begin
      drv(cm[s - 4], 1'b0, 1'b0, 1'b0);
      chk("multi speed", 32'h100 + s, 32'(freq));
    end
    apb(1'b1, 12'(`OFS_PRESET_BASE + 28), 32'h270f);
    drv(4'h8, 1'b0, 1'b0, 1'b0);
    chk("extra alone", 32'h64, 32'(freq));
  endtask

  task automatic t_modes;
    apb(1'b1, `OFS_CONTROL, 32'h3);
    drv(4'h1, 1'b0, 1'b0, 1'b0);
    chk("combined mode preset", 32'h64, 32'(freq));
    apb(1'b1, `OFS_CONTROL, 32'h1);
    drv(4'h1, 1'b0, 1'b0, 1'b0);
    chk("panel mode source", 32'(`SRC_NONE), 32'(src));
    for (int r = 1; r < 4; r++) begin
      apb(1'b1, `OFS_CONTROL, 32'h2 | (r << 4));
      drv(4'h7, 1'b0, 1'b0, 1'b0);
      chk("remote source", 32'(`SRC_NONE), 32'(src));
      chk("remote controls", 32'h7, {29'h0, rinc, rdec, rclr});
      chk("remote store", 32'(r == 1), 32'(rste));
    end
    drv(4'h0, 1'b0, 1'b1, 1'b0);
    fwd <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("clear at stop", 32'h1, {31'h0, rclr});
    @(posedge pclk);
    chk("clear pulse", 32'h0, {31'h0, rclr});
  endtask

  task automatic t_jog;
    apb(1'b1, `OFS_CONTROL, 32'h2);
    sfs <= 1'b1;
    drv(4'h4, 1'b1, 1'b1, 1'b0);
    chk("jog run", 32'h1, {31'h0, jogr});
    chk("jog freq", 32'h32, 32'(freq));
    chk("jog ramp", 32'h5, 32'(rtime));
    chk("ramp reference", 32'h258, 32'(rref));
    chk("second functions", 32'h1, {30'h0, srs, sfo});
    drv(4'h4, 1'b1, 1'b0, 1'b1);
    chk("jog reverse", 32'h1, {31'h0, rrev});
    drv(4'h4, 1'b1, 1'b0, 1'b0);
    chk("jog stop", 32'h1, {29'h0, jogr, run, srs});
    apb(1'b1, `OFS_CONTROL, 32'h3);
    drv(4'h0, 1'b1, 1'b1, 1'b0);
    chk("jog disabled", 32'h0, {31'h0, jogr});
    apb(1'b1, `OFS_CONTROL, 32'h2);
    civ <= 1'b1;
    viv <= 1'b1;
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    chk("current first", 32'h1f4, 32'(freq));
    civ <= 1'b0;
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    chk("voltage last", 32'h100, 32'(freq));
    viv <= 1'b0;
    sfs <= 1'b0;
  endtask

  task automatic t_panel;
    apb(1'b1, `OFS_CONTROL, 32'h1);
    pjm <= 1'b1;
    prk <= 1'b1;
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    chk("panel jog held", 32'h1, {31'h0, jogr});
    prk <= 1'b0;
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    chk("panel jog released", 32'h0, {31'h0, jogr});
    pjm <= 1'b0;
    apb(1'b1, `OFS_CONTROL, 32'h4);
    ufk <= 1'b1;
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    ufk <= 1'b0;
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    chk("key start", 32'h1, {31'h0, run});
    psk <= 1'b1;
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    chk("key stop", 32'h0, {31'h0, run});
    psk <= 1'b0;
    urk <= 1'b1;
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    chk("reverse key start", 32'h1, {31'h0, run});
    urk <= 1'b0;
  endtask

  // Cuts a hung run short.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report;
    end
  end

  // Reset, then the scenarios in turn.
  initial begin
    {presetn, psel, penable, pwrite, combo, jog, fwd, rev, sfs, pjm, prk, psk, ufk, urk} = '0;
    {paddr, pwdata} = '0;
    {civ, viv} = 2'h0;
    cif = 16'h1f4;
    vif = 16'h100;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_defaults;
    t_three;
    t_multi;
    t_modes;
    t_jog;
    t_panel;
    final_report;
  end
endmodule
